// >>> verilog/fbh_defines.svh
// timing counts and address-field constants for the flash bus host
`ifndef FBH_DEFINES_SVH
`define FBH_DEFINES_SVH

`define FBH_CLK_PERIOD_NS 8
`define FBH_ADDR_ACCESS_NS 70
`define FBH_SELECT_ACCESS_NS 70
`define FBH_OUTPUT_ACCESS_NS 30
`define FBH_WRITE_PULSE_NS 35
`define FBH_WRITE_HIGH_NS 30
`define FBH_SETUP_NS 10
`define FBH_CEIL_CYC(ns) (((ns) + `FBH_CLK_PERIOD_NS - 1) / `FBH_CLK_PERIOD_NS)
`define FBH_READ_CYC `FBH_CEIL_CYC(`FBH_SELECT_ACCESS_NS)
`define FBH_WPULSE_CYC `FBH_CEIL_CYC(`FBH_WRITE_PULSE_NS)
`define FBH_WHIGH_CYC `FBH_CEIL_CYC(`FBH_WRITE_HIGH_NS)
`define FBH_SETUP_CYC `FBH_CEIL_CYC(`FBH_SETUP_NS)
`define FBH_ADDR_W 19
`define FBH_DATA_W 8
`define FBH_PROT_A6 6
`define FBH_PROT_A1 1
`define FBH_PROT_A0 0

`endif

// >>> verilog/fbh_pkg.sv
// types for the flash bus host
package fbh_pkg;
    typedef enum logic [2:0] {
        FBH_IDLE = 3'b000,
        FBH_SETUP = 3'b001,
        FBH_ACTIVE = 3'b010,
        FBH_RECOVER = 3'b011
    } fbh_state_t;
    typedef enum logic [1:0] {
        FBH_OP_READ = 2'b00,
        FBH_OP_WRITE = 2'b01,
        FBH_OP_PROTECT = 2'b10,
        FBH_OP_UNPROTECT = 2'b11
    } fbh_op_t;
endpackage

// >>> verilog/fbh_host.sv
// host controller driving an asynchronous byte-wide flash over its pins
`include "fbh_defines.svh"

// Contract
// - read with select and output gate low, write strobe high.
// - write with select and write strobe low, output gate high.
// - all nineteen address lines are driven for every read and write.
// - protect uses A6 low, A1 high, A0 low; unprotect A6 high.
module fbh_host #(
    parameter int ADDR_W = `FBH_ADDR_W,
    parameter int DATA_W = `FBH_DATA_W,
    parameter int READ_CYC = `FBH_READ_CYC,
    parameter int WPULSE_CYC = `FBH_WPULSE_CYC,
    parameter int WHIGH_CYC = `FBH_WHIGH_CYC,
    parameter int SETUP_CYC = `FBH_SETUP_CYC
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic req_valid_in,
    input wire fbh_pkg::fbh_op_t req_op_in,
    input wire logic [ADDR_W-1:0] req_addr_in,
    input wire logic [DATA_W-1:0] req_wdata_in,
    output logic req_ready_out,
    output logic rsp_valid_out,
    output logic [DATA_W-1:0] rsp_rdata_out,
    output logic [ADDR_W-1:0] flash_addr_out,
    input wire logic [DATA_W-1:0] flash_data_in,
    output logic [DATA_W-1:0] flash_data_out,
    output logic flash_data_oe_out,
    output logic flash_select_n_out,
    output logic flash_out_gate_n_out,
    output logic flash_write_n_out
);
    logic [1:0] rst_sync_q;
    logic rst_n;
    fbh_pkg::fbh_state_t state_q;
    fbh_pkg::fbh_op_t op_q;
    logic [7:0] cnt_q;
    logic is_read;

    // a request is taken only while ready stands at the edge
    logic take;


    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    assign is_read = (op_q == fbh_pkg::FBH_OP_READ);

    assign take = (state_q == fbh_pkg::FBH_IDLE) && req_valid_in &&
                  req_ready_out;


    // sequencer: setup with strobes high, active phase, recovery gap
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= fbh_pkg::FBH_IDLE;
            op_q <= fbh_pkg::FBH_OP_READ;
            cnt_q <= 8'h00;
        end else begin
            unique case (state_q)
                fbh_pkg::FBH_IDLE: begin
                    if (take) begin
                        op_q <= req_op_in;
                        cnt_q <= 8'(SETUP_CYC);
                        state_q <= fbh_pkg::FBH_SETUP;
                    end
                end
                fbh_pkg::FBH_SETUP: begin
                    if (cnt_q <= 8'h01) begin
                        // full select access time covers wake from standby
                        cnt_q <= is_read ? 8'(READ_CYC) : 8'(WPULSE_CYC);
                        state_q <= fbh_pkg::FBH_ACTIVE;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                fbh_pkg::FBH_ACTIVE: begin
                    if (cnt_q <= 8'h01) begin
                        cnt_q <= 8'(WHIGH_CYC);
                        state_q <= fbh_pkg::FBH_RECOVER;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                fbh_pkg::FBH_RECOVER: begin
                    if (cnt_q <= 8'h01) begin
                        state_q <= fbh_pkg::FBH_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                default: state_q <= fbh_pkg::FBH_IDLE;
            endcase
        end
    end

    // address held through the whole cycle
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            flash_addr_out <= '0;
            flash_data_out <= '0;
        end else if (take) begin
            flash_addr_out <= req_addr_in;
            flash_data_out <= req_wdata_in;
            unique case (req_op_in)
                fbh_pkg::FBH_OP_PROTECT: begin
                    flash_addr_out[`FBH_PROT_A6] <= 1'b0;
                    flash_addr_out[`FBH_PROT_A1] <= 1'b1;
                    flash_addr_out[`FBH_PROT_A0] <= 1'b0;
                end
                fbh_pkg::FBH_OP_UNPROTECT: begin
                    flash_addr_out[`FBH_PROT_A6] <= 1'b1;
                    flash_addr_out[`FBH_PROT_A1] <= 1'b1;
                    flash_addr_out[`FBH_PROT_A0] <= 1'b0;
                end
                default: begin
                end
            endcase
        end
    end

    // control pins; select stays high through setup so address precedes strobe
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            flash_select_n_out <= 1'b1;
            flash_out_gate_n_out <= 1'b1;
            flash_write_n_out <= 1'b1;
            flash_data_oe_out <= 1'b0;
        end else begin
            flash_select_n_out <= !(state_q == fbh_pkg::FBH_ACTIVE &&
                                    !(cnt_q <= 8'h01));
            if (state_q == fbh_pkg::FBH_SETUP && cnt_q <= 8'h01) begin
                flash_select_n_out <= 1'b0;
                flash_out_gate_n_out <= !is_read;
                flash_write_n_out <= is_read;
                // drive data only with gate high, avoiding contention
                flash_data_oe_out <= !is_read;
            end else if (state_q == fbh_pkg::FBH_ACTIVE && cnt_q <= 8'h01) begin
                // write strobe rises here; data held one more cycle
                flash_select_n_out <= 1'b1;
                flash_out_gate_n_out <= 1'b1;
                flash_write_n_out <= 1'b1;
            end else if (state_q != fbh_pkg::FBH_ACTIVE) begin
                flash_data_oe_out <= 1'b0;
            end
        end
    end


    // capture read data at end of access window
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid_out <= 1'b0;
            rsp_rdata_out <= '0;
        end else begin
            rsp_valid_out <= 1'b0;
            if (state_q == fbh_pkg::FBH_ACTIVE && cnt_q <= 8'h01) begin
                rsp_valid_out <= 1'b1;
                if (is_read) begin
                    rsp_rdata_out <= flash_data_in;
                end
            end
        end
    end


    // ready is registered, so it is raised one edge early: on the last
    // recovery cycle, and held in idle until a request is taken.
    // a requester that holds valid through recovery is still served,
    // since ready no longer depends on valid being low
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            req_ready_out <= 1'b0;
        end else begin
            req_ready_out <= ((state_q == fbh_pkg::FBH_IDLE) && !take) ||
                             ((state_q == fbh_pkg::FBH_RECOVER) &&
                              (cnt_q <= 8'h01));
        end
    end

endmodule

// >>> tb/fbh_assertions.sv
// pin-level checks on the flash bus host
module fbh_assertions (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic req_valid_in,
    input wire fbh_pkg::fbh_op_t req_op_in,
    input wire logic [18:0] req_addr_in,
    input wire logic req_ready_out,
    input wire logic rsp_valid_out,
    input wire logic [18:0] flash_addr_out,
    input wire logic flash_data_oe_out,
    input wire logic flash_select_n_out,
    input wire logic flash_out_gate_n_out,
    input wire logic flash_write_n_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    logic take;
    assign take = req_valid_in && req_ready_out;
    chk_read_strobes: assert property (
        !flash_select_n_out && !flash_out_gate_n_out |-> flash_write_n_out)
        else $error("read cycle with write strobe low");
    chk_write_strobes: assert property (
        !flash_write_n_out |-> !flash_select_n_out && flash_out_gate_n_out)
        else $error("write strobe without select or with gate low");
    chk_drive_gate: assert property (
        flash_data_oe_out |-> flash_out_gate_n_out)
        else $error("host drives data while gate low");
    chk_write_width: assert property (
        $fell(flash_write_n_out) |-> !flash_write_n_out [*4])
        else $error("write strobe too short");
    chk_addr_take: assert property (
        take && req_op_in == fbh_pkg::FBH_OP_READ
        |=> flash_addr_out == $past(req_addr_in))
        else $error("read address not presented");
    chk_addr_hold: assert property (
        !flash_select_n_out && !$past(flash_select_n_out)
        |-> $stable(flash_addr_out))
        else $error("address moved while selected");
    chk_prot_bits: assert property (
        take && req_op_in == fbh_pkg::FBH_OP_PROTECT
        |=> !flash_addr_out[6] && flash_addr_out[1] && !flash_addr_out[0])
        else $error("protect address bits wrong");
    chk_unprot_bits: assert property (
        take && req_op_in == fbh_pkg::FBH_OP_UNPROTECT
        |=> flash_addr_out[6] && flash_addr_out[1] && !flash_addr_out[0])
        else $error("unprotect address bits wrong");
    chk_answer_due: assert property (
        take |-> ##[8:12] rsp_valid_out)
        else $error("no answer after request");
endmodule

bind fbh_host fbh_assertions u_chk (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .req_valid_in(req_valid_in), .req_op_in(req_op_in),
    .req_addr_in(req_addr_in), .req_ready_out(req_ready_out),
    .rsp_valid_out(rsp_valid_out), .flash_addr_out(flash_addr_out),
    .flash_data_oe_out(flash_data_oe_out),
    .flash_select_n_out(flash_select_n_out),
    .flash_out_gate_n_out(flash_out_gate_n_out),
    .flash_write_n_out(flash_write_n_out));

// >>> tb/fbh_flash_model.sv
// behavioural flash device facing the host pins
module fbh_flash_model #(
    parameter logic [7:0] ID_CODE = 8'hC3 // arbitrary value
) (
    input wire logic [18:0] addr_in,
    input wire logic [7:0] host_data_in,
    input wire logic host_oe_in,
    input wire logic select_n_in,
    input wire logic out_gate_n_in,
    input wire logic write_n_in,
    output logic [7:0] data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic id_mode = 1'b0; // array read from power-up
    logic [7:0] cmd_q; // command latch, absent from read map
    logic ready = 1'b0;
    logic [7:0] last = 8'h00;
    logic drive;
    logic [7:0] word;
    always @(negedge select_n_in) begin
        ready = 1'b0;
        #70 ready = !select_n_in;
    end
    // first rising strobe of the pair takes the data
    always @(posedge (write_n_in | select_n_in)) begin
        cmd_q = host_data_in;
        id_mode = (cmd_q == 8'h90); // other writes fall back
    end
    assign drive = !select_n_in && !out_gate_n_in && write_n_in && ready;
    assign word = id_mode ? ID_CODE : addr_in[7:0] ^ 8'h5A;
    always @(drive or word) begin
        if (drive) last = word;
    end
    // released lines show the inverse, never the stale byte
    assign data_out = host_oe_in ? host_data_in : drive ? word : ~last;
endmodule

// >>> tb/fbh_host_bench.sv
// self-checking bench for the flash bus host
module fbh_host_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {fbh_pkg::fbh_op_t op; logic [18:0] a; logic [7:0] d, x;} fbh_row_t;
    logic clk_in = 1'b0, reset_n_in = 1'b0, req_valid_in = 1'b0;
    fbh_pkg::fbh_op_t req_op_in = fbh_pkg::FBH_OP_READ;
    logic [18:0] req_addr_in = 19'h00000, flash_addr_out;
    logic [7:0] req_wdata_in = 8'h00, rsp_rdata_out, flash_data_in;
    logic [7:0] flash_data_out;
    logic req_ready_out, rsp_valid_out, flash_data_oe_out;
    logic flash_select_n_out, flash_out_gate_n_out, flash_write_n_out;
    int err_count = 0, n_tests = 0;
    fbh_row_t rows [9] = '{
        '{fbh_pkg::FBH_OP_READ, 19'h00012, 8'h00, 8'h48},
        '{fbh_pkg::FBH_OP_READ, 19'h7FFFF, 8'h00, 8'hA5},
        '{fbh_pkg::FBH_OP_WRITE, 19'h00555, 8'h90, 8'h00},
        '{fbh_pkg::FBH_OP_READ, 19'h00000, 8'h00, 8'hC3},
        '{fbh_pkg::FBH_OP_WRITE, 19'h00000, 8'hF0, 8'h00},
        '{fbh_pkg::FBH_OP_READ, 19'h00003, 8'h00, 8'h59},
        '{fbh_pkg::FBH_OP_PROTECT, 19'h70000, 8'h00, 8'h00},
        '{fbh_pkg::FBH_OP_UNPROTECT, 19'h30042, 8'h00, 8'h00},
        '{fbh_pkg::FBH_OP_READ, 19'h00040, 8'h00, 8'h1A}};
    fbh_host DUT (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .req_valid_in(req_valid_in), .req_op_in(req_op_in),
        .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
        .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
        .rsp_rdata_out(rsp_rdata_out), .flash_addr_out(flash_addr_out),
        .flash_data_in(flash_data_in), .flash_data_out(flash_data_out),
        .flash_data_oe_out(flash_data_oe_out),
        .flash_select_n_out(flash_select_n_out),
        .flash_out_gate_n_out(flash_out_gate_n_out),
        .flash_write_n_out(flash_write_n_out));
    fbh_flash_model u_flash (.addr_in(flash_addr_out),
        .host_data_in(flash_data_out), .host_oe_in(flash_data_oe_out),
        .select_n_in(flash_select_n_out),
        .out_gate_n_in(flash_out_gate_n_out),
        .write_n_in(flash_write_n_out), .data_out(flash_data_in));
    initial forever #4 clk_in = ~clk_in;
    task automatic chk(input logic [18:0] got, input logic [18:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("mismatches %0d of %0d checks", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // valid held until the take edge, then the answer waited for
    task automatic run(input fbh_row_t r);
        int n;
        @(posedge clk_in);
        req_valid_in <= 1'b1;
        req_op_in <= r.op;
        req_addr_in <= r.a;
        req_wdata_in <= r.d;
        do @(posedge clk_in); while (req_ready_out !== 1'b1);
        req_valid_in <= 1'b0;
        n = 0;
        do begin
            @(negedge clk_in);
            n++;
        end while (rsp_valid_out !== 1'b1 && n < 40);
        chk(rsp_valid_out, 1'b1);
        if (r.op == fbh_pkg::FBH_OP_READ) chk(rsp_rdata_out, r.x);
    endtask
    initial begin
        repeat (16) @(posedge clk_in);
        chk({flash_select_n_out, flash_write_n_out, flash_data_oe_out}, 3'b110);
        reset_n_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        foreach (rows[i]) run(rows[i]);
        // reset dropped in the middle of a read
        @(posedge clk_in);
        req_valid_in <= 1'b1;
        repeat (6) @(posedge clk_in);
        reset_n_in <= 1'b0;
        req_valid_in <= 1'b0;
        @(negedge clk_in);
        chk({flash_select_n_out, flash_out_gate_n_out, flash_data_oe_out}, 3'b110);
        @(posedge clk_in);
        reset_n_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        run(rows[1]);
        end_sim;
    end
    initial begin
        #20000;
        err_count++;
        end_sim;
    end
endmodule
